// ===== rtl/adc_status_pkg.sv
// shared constants, types and the pin synchroniser of the status word block
`timescale 1ns/1ns
`default_nettype none
package adc_status_pkg;
    // word layout
    localparam int DATA_W = 24;
    localparam int TAG_W = 5;
    localparam int STAT_W = 8;
    localparam int FRAME_W = 32;
    localparam int CMD_W = 8;
    localparam int NEW_BIT = 7;
    localparam int OVF_BIT = 6;
    localparam int SUPPLY_BIT = 5;
    localparam logic [5:0] BITS_WITH_STATUS = 6'h20;
    localparam logic [5:0] BITS_DATA_ONLY = 6'h18;
    localparam logic [3:0] CMD_LEN = 4'h8;
    localparam logic [2:0] CMD_CH_READ = 3'h1;
    localparam logic [TAG_W-1:0] TAG_FIXED = 5'h00;
    localparam logic [TAG_W-1:0] TAG_LAST_DIFF = 5'h07;
    localparam logic [DATA_W-1:0] POS_FS = 24'h7FFFFF;
    localparam logic [DATA_W-1:0] NEG_FS = 24'h800000;
    // supply monitor, in millivolts: 4300 trip, 50 hysteresis
    localparam logic [12:0] SUPPLY_TRIP_MV = 13'h10CC;
    localparam logic [12:0] SUPPLY_HYST_MV = 13'h0032;
    localparam logic [12:0] SUPPLY_REL_MV = SUPPLY_TRIP_MV + SUPPLY_HYST_MV;
    // register port
    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATE = 4'h1;
    localparam logic [3:0] REG_IRQ_STAT = 4'h2;
    localparam logic [3:0] REG_IRQ_MASK = 4'h3;
    localparam int CTRL_STAT_EN = 0;
    localparam int CTRL_AUTO = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam int IRQ_NEW = 0;
    localparam int IRQ_OVF = 1;
    localparam int IRQ_SUPPLY = 2;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_CMD = 2'b01,
        SER_DATA = 2'b10,
        SER_DONE = 2'b11
    } ser_e;

    typedef struct packed {
        logic new_flag;
        logic ovf;
        logic supply;
        logic [TAG_W-1:0] tag;
        logic [DATA_W-1:0] data;
    } conv_result_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } reg_req_s;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic din;
    } spi_pins_s;
endpackage : adc_status_pkg

// two flip-flop synchroniser for pin inputs
module pin_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_s;
    sync_s st_q, st_d;

    // first stage feeds only the second
    always_comb begin
        st_d = st_q;
        if (ce_i) begin
            st_d.s1 = d_i;
            st_d.s2 = st_q.s1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= {INIT, INIT};
        end else begin
            st_q <= st_d;
        end
    end

    assign q_o = st_q.s2;
endmodule : pin_sync
`default_nettype wire

// ===== rtl/adc_status_word.sv
// status byte and result word capture with serial read-out
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - fresh flag is set when a new, unreturned result is delivered.
// - fresh flag stays set until the host reads channel data.
// - a repeat read returns the old result with the fresh flag clear.
// - an unread result is overwritten by the next conversion.
// - fresh flag reads 0 with no update since last read, else 1.
// - over-range flag is set when input magnitude exceeds converter range.
// - over-range saturates the result at positive or negative full scale.
// - low-supply flag sets below 4.3 V, clears 50 mV above that.
// - in auto-scan the channel tag names the result's input channel.
// - in fixed-channel mode the channel tag has no defined meaning.
// - result is 24 bits, bit 23 most significant, bit 0 least.
// - result is two's complement.
// - tags 00h-07h are differential pairs, 08h up single-ended inputs.
// - with status enabled read gives status then three bytes, MSB first.
module adc_status_word (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire adc_status_pkg::reg_req_s reg_req_i,
    output logic [7:0] reg_rdata_o,
    input wire logic conv_valid_i,
    input wire logic [adc_status_pkg::DATA_W:0] filt_data_i,
    input wire logic mod_overload_i,
    input wire logic [adc_status_pkg::TAG_W-1:0] scan_tag_i,
    input wire logic [12:0] supply_mv_i,
    input wire adc_status_pkg::spi_pins_s spi_i,
    output logic dout_o,
    output logic dout_oe_o,
    output logic result_ready_n_pin_o,
    output logic irq_o
);
    import adc_status_pkg::*;

    typedef struct packed {
        conv_result_s res;
        logic supply_low;
        logic [1:0] ctrl;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [7:0] rdata;
        ser_e sst;
        logic sclk_prev;
        logic [5:0] bit_cnt;
        logic [5:0] frame_bits;
        logic [CMD_W-1:0] cmd;
        logic [FRAME_W-1:0] shreg;
        logic dout;
        logic dout_oe;
        logic ready_n;
        logic irq;
    } state_s;

    localparam state_s ST_RESET = '{
        res: '0, supply_low: 1'b0, ctrl: CTRL_RESET, irq_stat: 3'h0,
        irq_mask: IRQ_MASK_RESET, rdata: 8'h00, sst: SER_IDLE,
        sclk_prev: 1'b0, bit_cnt: 6'h00, frame_bits: 6'h00, cmd: 8'h00,
        shreg: 32'h00000000, dout: 1'b0, dout_oe: 1'b0, ready_n: 1'b1,
        irq: 1'b0};

    // the status byte layout is fixed by the word format
    if (DATA_W != 24 || TAG_W != 5 || FRAME_W != STAT_W + DATA_W) begin
        : g_check
        $error("adc_status_word: unsupported word layout");
    end

    state_s q, d;
    spi_pins_s pins;
    logic read_take;
    logic pos_ovf;
    logic neg_ovf;
    logic ovf_now;
    logic [DATA_W-1:0] sat_data;
    logic [STAT_W-1:0] status_byte;
    logic [FRAME_W-1:0] frame;
    logic [2:0] events;
    logic [7:0] w1c;

    // pins cross into the system clock; cs idles high
    pin_sync #(.W(3), .INIT(3'h2)) u_pin_sync (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .d_i(spi_i),
        .q_o(pins)
    );

    // saturate the filter word and flag overload
    always_comb begin
        pos_ovf = ~filt_data_i[DATA_W] & filt_data_i[DATA_W-1];
        neg_ovf = filt_data_i[DATA_W] & ~filt_data_i[DATA_W-1];
        ovf_now = mod_overload_i | pos_ovf | neg_ovf;
        if (ovf_now) begin
            // sign of the wide word picks the rail
            sat_data = filt_data_i[DATA_W] ? NEG_FS : POS_FS;
        end else begin
            sat_data = filt_data_i[DATA_W-1:0];
        end
    end

    // live status byte and the outgoing frame, msb first
    always_comb begin
        status_byte = {q.res.new_flag, q.res.ovf, q.res.supply, q.res.tag};
        if (q.ctrl[CTRL_STAT_EN]) begin
            frame = {status_byte, q.res.data};
        end else begin
            frame = {q.res.data, 8'h00};
        end
    end

    // next state of the whole block
    always_comb begin
        d = q;
        read_take = 1'b0;
        events = 3'h0;
        w1c = 8'h00;
        if (ce_i) begin
            d.sclk_prev = pins.sclk;
            d.rdata = 8'h00;

            // supply comparator with hysteresis
            if (supply_mv_i < SUPPLY_TRIP_MV) begin
                d.supply_low = 1'b1;
            end else if (supply_mv_i >= SUPPLY_REL_MV) begin
                d.supply_low = 1'b0;
            end
            events[IRQ_SUPPLY] = d.supply_low & ~q.supply_low;

            // serial engine: command in on rise, data out on fall
            case (q.sst)
                SER_IDLE: begin
                    if (!pins.cs_n) begin
                        d.sst = SER_CMD;
                        d.dout_oe = 1'b1;
                        d.bit_cnt = 6'h00;
                    end
                end
                SER_CMD: begin
                    if (pins.sclk && !q.sclk_prev) begin
                        d.cmd = {q.cmd[CMD_W-2:0], pins.din};
                        d.bit_cnt = q.bit_cnt + 6'h01;
                    end else if (!pins.sclk && q.sclk_prev &&
                            q.bit_cnt == {2'b00, CMD_LEN}) begin
                        if (q.cmd[7:5] == CMD_CH_READ) begin
                            read_take = 1'b1;
                            d.dout = frame[FRAME_W-1];
                            d.shreg = {frame[FRAME_W-2:0], 1'b0};
                            d.bit_cnt = 6'h01;
                            d.frame_bits = q.ctrl[CTRL_STAT_EN] ?
                                BITS_WITH_STATUS : BITS_DATA_ONLY;
                            d.sst = SER_DATA;
                        end else begin
                            // other commands belong to the command decoder
                            d.sst = SER_DONE;
                        end
                    end
                end
                SER_DATA: begin
                    if (!pins.sclk && q.sclk_prev) begin
                        if (q.bit_cnt == q.frame_bits) begin
                            d.dout = 1'b0;
                            d.sst = SER_DONE;
                        end else begin
                            d.dout = q.shreg[FRAME_W-1];
                            d.shreg = {q.shreg[FRAME_W-2:0], 1'b0};
                            d.bit_cnt = q.bit_cnt + 6'h01;
                        end
                    end
                end
                SER_DONE: begin
                    d.dout = 1'b0;
                end
                default: begin
                    d.sst = SER_IDLE;
                end
            endcase
            if (pins.cs_n) begin
                d.sst = SER_IDLE;
                d.dout_oe = 1'b0;
                d.dout = 1'b0;
                d.cmd = 8'h00;
            end

            // a read hands out the word and clears freshness
            if (read_take) begin
                d.res.new_flag = 1'b0;
                d.ready_n = 1'b1;
            end
            // new result overwrites any unread one; set wins over clear
            if (conv_valid_i) begin
                d.res.data = sat_data;
                d.res.new_flag = 1'b1;
                d.res.ovf = ovf_now;
                d.res.supply = d.supply_low;
                // in auto-scan the tag comes from the sequencer, otherwise it is TAG_FIXED
                d.res.tag = q.ctrl[CTRL_AUTO] ?
                    scan_tag_i : TAG_FIXED;
                d.ready_n = 1'b0;
                events[IRQ_NEW] = 1'b1;
                events[IRQ_OVF] = ovf_now;
            end

            // register writes
            if (reg_req_i.we) begin
                if (reg_req_i.addr == REG_CTRL) begin
                    d.ctrl = reg_req_i.wdata[1:0];
                end else if (reg_req_i.addr == REG_IRQ_STAT) begin
                    w1c = reg_req_i.wdata;
                end else if (reg_req_i.addr == REG_IRQ_MASK) begin
                    d.irq_mask = reg_req_i.wdata[2:0];
                end
            end
            d.irq_stat = (q.irq_stat & ~w1c[2:0]) | events;

            // register reads, unmapped reads give zero
            if (reg_req_i.re) begin
                if (reg_req_i.addr == REG_CTRL) begin
                    d.rdata = {6'h00, q.ctrl};
                end else if (reg_req_i.addr == REG_STATE) begin
                    d.rdata = status_byte;
                end else if (reg_req_i.addr == REG_IRQ_STAT) begin
                    d.rdata = {5'h00, q.irq_stat};
                end else if (reg_req_i.addr == REG_IRQ_MASK) begin
                    d.rdata = {5'h00, q.irq_mask};
                end
            end
            d.irq = |(d.irq_stat & d.irq_mask);
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= ST_RESET;
        end else begin
            q <= d;
        end
    end

    // every output straight from the state register
    assign reg_rdata_o = q.rdata;
    assign dout_o = q.dout;
    assign dout_oe_o = q.dout_oe;
    assign result_ready_n_pin_o = q.ready_n;
    assign irq_o = q.irq;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    AST_FRESH_SET: assert property (
        ce_i && conv_valid_i |=> q.res.new_flag && !q.ready_n)
        else $error("fresh flag not set by new result");
    AST_FRESH_HOLD: assert property (
        q.res.new_flag && !(ce_i && read_take) |=> q.res.new_flag)
        else $error("fresh flag dropped without a read");
    AST_REREAD_CLEAR: assert property (
        ce_i && read_take && !conv_valid_i |=> !q.res.new_flag
            && q.res.data == $past(q.res.data))
        else $error("repeat read did not clear fresh flag");
    AST_OVERWRITE: assert property (
        ce_i && conv_valid_i |=> q.res.data == $past(sat_data))
        else $error("unread result not overwritten");
    AST_OVF_FLAG: assert property (
        ce_i && conv_valid_i && (pos_ovf || neg_ovf) |=> q.res.ovf)
        else $error("over-range flag missing");
    AST_SAT_RAIL: assert property (
        ce_i && conv_valid_i && ovf_now && filt_data_i[DATA_W]
            |=> q.res.data == NEG_FS)
        else $error("negative overload not at full scale");
    AST_SUPPLY_LOW: assert property (
        ce_i && supply_mv_i < SUPPLY_TRIP_MV |=> q.supply_low
            ##1 (q.supply_low || $past(supply_mv_i) >= SUPPLY_REL_MV
            || !$past(ce_i)))
        else $error("low supply flag wrong");
    AST_TAG_AUTO: assert property (
        ce_i && conv_valid_i && q.ctrl[CTRL_AUTO]
            |=> q.res.tag == $past(scan_tag_i))
        else $error("channel tag not captured");
    AST_FRAME_HEAD: assert property (
        ce_i && read_take && q.ctrl[CTRL_STAT_EN]
            |=> q.dout == $past(status_byte[NEW_BIT])
            && q.shreg[FRAME_W-1 -: 7] == $past(status_byte[6:0]))
        else $error("frame does not start with status byte");
    AST_CAPTURE: assert property (
        ce_i && conv_valid_i |=> q.res.supply == q.supply_low)
        else $error("supply flag not captured with result");

    COV_READ_STATUS: cover property (
        read_take && q.ctrl[CTRL_STAT_EN] && q.res.new_flag);
    COV_READ_DATA_ONLY: cover property (
        read_take && !q.ctrl[CTRL_STAT_EN]);
    COV_REREAD: cover property (read_take && !q.res.new_flag);
    COV_OVERRANGE: cover property (conv_valid_i && ovf_now);
endmodule : adc_status_word
`default_nettype wire

// ===== sim/host_model.sv
// behavioural host that reads result frames over the serial pins
`timescale 1ns/1ns
`default_nettype none
module host_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o,
    input wire logic dout_i
);
    // idle: deselected, clock parked low
    initial begin
        sclk_o = 1'h0;
        cs_n_o = 1'h1;
        din_o = 1'h0;
    end

    // command byte, then nbits shifted out; din toggles once released
    task automatic frame(input logic [7:0] cmd, input int nbits,
                         output logic [31:0] got);
        got = '0;
        #3; // off the system clock grid
        cs_n_o = 1'h0;
        #100;
        for (int i = 0; i < 8 + nbits; i++) begin
            din_o = (i < 8) ? cmd[7 - i] : ~din_o;
            #40 sclk_o = 1'h1;
            // sampled late in the high phase: covers pin sync latency
            #35;
            if (i >= 8) begin
                got = {got[30:0], dout_i};
            end
            #5 sclk_o = 1'h0;
        end
        #100 cs_n_o = 1'h1;
        din_o = ~din_o;
        #200;
    endtask : frame
endmodule : host_model
`default_nettype wire

// ===== sim/adc_status_word_tb.sv
// self-checking bench for the status and data word block
`timescale 1ns/1ns
`default_nettype none
module adc_status_word_tb;
    import adc_status_pkg::*;
    logic clk, nrst, ce, conv, ovl, dout, oe, rdy_n, irq, sclk, cs_n, din;
    logic [24:0] filt;
    logic [4:0] tag;
    logic [12:0] mv;
    logic [7:0] rdata, rd;
    logic [31:0] got;
    reg_req_s req;
    spi_pins_s spi;
    int bad_count, n_tests, cycles;

    adc_status_word u_dut (.clk_sys_i(clk), .nrst_i(nrst), .ce_i(ce),
        .reg_req_i(req), .reg_rdata_o(rdata), .conv_valid_i(conv),
        .filt_data_i(filt), .mod_overload_i(ovl), .scan_tag_i(tag),
        .supply_mv_i(mv), .spi_i(spi), .dout_o(dout), .dout_oe_o(oe),
        .result_ready_n_pin_o(rdy_n), .irq_o(irq));
    host_model u_host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din),
        .dout_i(oe ? dout : 1'h1)); // released line idles high
    assign spi = {sclk, cs_n, din};

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // hang guard, far above the few thousand cycles needed
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, we: 1'h1, re: 1'h0};
        @(posedge clk);
        req.we <= 1'h0;
    endtask : wr_reg

    // data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, we: 1'h0, re: 1'h1};
        @(posedge clk);
        req.re <= 1'h0;
        #1 rd = rdata;
    endtask : rd_reg

    task automatic cv(input logic [24:0] f, input logic o,
                      input logic [4:0] t);
        @(posedge clk);
        conv <= 1'h1;
        filt <= f;
        ovl <= o;
        tag <= t;
        @(posedge clk);
        conv <= 1'h0;
        @(posedge clk);
        #1;
    endtask : cv

    task automatic t_reset();
        chk(rdy_n, 1'h1);
        chk(irq, 1'h0);
        rd_reg(REG_CTRL);
        chk(rd, 8'h01);
        rd_reg(REG_IRQ_MASK);
        chk(rd, 8'h00);
        rd_reg(4'hF); // unmapped
        chk(rd, 8'h00);
        wr_reg(REG_CTRL, 8'h03);
    endtask : t_reset

    task automatic t_fresh();
        cv(25'h0123456, 1'h0, 5'h03);
        chk(rdy_n, 1'h0);
        repeat (50) @(posedge clk);
        rd_reg(REG_STATE);
        chk(rd, 8'h83);
        u_host.frame(8'h30, 32, got);
        chk(got, 32'h83123456);
        chk(rdy_n, 1'h1);
        u_host.frame(8'h30, 32, got);
        chk(got, 32'h03123456);
        rd_reg(REG_STATE);
        chk(rd, 8'h03);
        // back to back results: the first is lost
        cv(25'h0111111, 1'h0, 5'h01);
        cv(25'h0222222, 1'h0, 5'h02);
        u_host.frame(8'h20, 32, got);
        chk(got, 32'h82222222);
    endtask : t_fresh

    task automatic t_range();
        logic [24:0] f[4] = '{25'h0800000, 25'h17FFFFF, 25'h1FFFFF0,
                              25'h1FFFFF0};
        logic [3:0] o = 4'h4;
        logic [31:0] e[4] = '{32'hC47FFFFF, 32'hC4800000, 32'hC4800000,
                              32'h84FFFFF0};
        for (int i = 0; i < 4; i++) begin
            cv(f[i], o[i], 5'h04);
            u_host.frame(8'h3F, 32, got);
            chk(got, e[i]);
        end
    endtask : t_range

    task automatic t_supply();
        logic [12:0] v[5] = '{13'h1388, 13'h10CC, 13'h10CB, 13'h10FD,
                              13'h10FE};
        logic [4:0] e = 5'h0C;
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            mv <= v[i];
            // the flag reaches the status byte only with a result
            cv(25'h0000100, 1'h0, 5'h05);
            rd_reg(REG_STATE);
            chk(rd[SUPPLY_BIT], e[i]);
        end
    endtask : t_supply

    task automatic t_tags();
        logic [4:0] t[4] = '{5'h00, 5'h07, 5'h08, 5'h17};
        for (int i = 0; i < 4; i++) begin
            cv(25'h0000010, 1'h0, t[i]);
            rd_reg(REG_STATE);
            chk(rd[4:0], t[i]);
        end
    endtask : t_tags

    // status byte and auto-scan off: data only, then the line rests at 0
    task automatic t_nostat();
        wr_reg(REG_CTRL, 8'h00);
        cv(25'h05A3C0F, 1'h0, 5'h08);
        u_host.frame(8'h30, 32, got);
        chk(got, 32'h5A3C0F00);
        rd_reg(REG_STATE);
        chk(rd, 8'h00);
        u_host.frame(8'h40, 32, got); // not a data read
        chk(got, 32'h00000000);
        chk(oe, 1'h0);
        wr_reg(REG_CTRL, 8'h03);
    endtask : t_nostat

    task automatic t_irq();
        wr_reg(REG_IRQ_MASK, 8'h07);
        wr_reg(REG_IRQ_STAT, 8'h07);
        rd_reg(REG_IRQ_STAT);
        chk(rd, 8'h00);
        cv(25'h0000001, 1'h0, 5'h00);
        @(posedge clk);
        #1 chk(irq, 1'h1);
        wr_reg(REG_IRQ_MASK, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk(irq, 1'h0);
        rd_reg(REG_IRQ_STAT);
        chk(rd, 8'h01);
        wr_reg(REG_IRQ_STAT, 8'h01);
        rd_reg(REG_IRQ_STAT);
        chk(rd, 8'h00);
    endtask : t_irq

    // clock enable low: a result pulse is ignored, state stays frozen
    task automatic t_ce();
        @(posedge clk);
        ce <= 1'h0;
        cv(25'h0000002, 1'h0, 5'h1F);
        @(posedge clk);
        ce <= 1'h1;
        rd_reg(REG_STATE);
        chk(rd, 8'h80);
        chk(rdy_n, 1'h0);
    endtask : t_ce

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    initial begin
        nrst = 1'h0;
        ce = 1'h1;
        conv = 1'h0;
        ovl = 1'h0;
        filt = '0;
        tag = '0;
        mv = 13'h1388;
        req = '0;
        bad_count = 0;
        n_tests = 0;
        repeat (10) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
        t_reset();
        t_fresh();
        t_range();
        t_supply();
        t_tags();
        t_nostat();
        t_irq();
        t_ce();
        final_report();
    end
endmodule : adc_status_word_tb
`default_nettype wire
